/* File: hw/smct_consts.svh */
// Offsets, field positions, reset values and cycle counts of the DRAM module command-timing block.
`ifndef SMCT_CONSTS_SVH
`define SMCT_CONSTS_SVH

// Data path geometry.
`define SMCT_DATA_W        72
`define SMCT_LANES         8
`define SMCT_LANE_W        9
`define SMCT_ROW_W         11
`define SMCT_COL_W         9
`define SMCT_MEM_AW        8

// Register byte addresses.
`define SMCT_CTRL_ADDR     4'h0
`define SMCT_STAT_ADDR     4'h4

// Control register fields and reset values.
`define SMCT_CTRL_BL_LSB   0
`define SMCT_CTRL_LAT3_BIT 4
`define SMCT_CTRL_BL_RST   2'h2
`define SMCT_CTRL_LAT3_RST 1'h1

// Status register fields.
`define SMCT_STAT_OPEN_LSB 0
`define SMCT_STAT_SELF_BIT 2
`define SMCT_STAT_SUSP_BIT 3
`define SMCT_STAT_RD_BIT   4
`define SMCT_STAT_WR_BIT   5
`define SMCT_STAT_LAT3_BIT 6

// Mode-set address fields.
`define SMCT_MS_BL_LSB     0
`define SMCT_MS_CL_LSB     4
`define SMCT_MS_CL2        3'h2
`define SMCT_MS_CL3        3'h3

// Cycle counts.
`define SMCT_READ_MASK_LAT 2

`endif

/* File: hw/smct_pkg.sv */
// Types shared by the DRAM module command-timing block.
package smct_pkg;

  typedef enum logic [3:0] {
    cmd_nop                = 4'h0,
    row_activate_cmd       = 4'h1,
    mode_set_cmd           = 4'h2,
    auto_refresh_cmd       = 4'h3,
    self_refresh_entry_cmd = 4'h4,
    read_cmd               = 4'h5,
    read_autoclose_cmd     = 4'h6,
    write_cmd              = 4'h7,
    write_autoclose_cmd    = 4'h8,
    bank_precharge_cmd     = 4'h9,
    all_bank_precharge_cmd = 4'ha
  } smct_cmd_t;

  typedef enum logic [2:0] {
    burst_idle  = 3'b001,
    burst_read  = 3'b010,
    burst_write = 3'b100
  } smct_burst_t;

endpackage

/* File: hw/smct_mem.sv */
// Byte-lane writable storage array with a registered read port.
`timescale 1ns/1ns
`include "smct_consts.svh"
module smct_mem (
  // Clock
  input  wire logic                       clk,
  // Write port
  input  wire logic                       we,
  input  wire logic [`SMCT_LANES-1:0]     lane_we,
  input  wire logic [`SMCT_MEM_AW-1:0]    waddr,
  input  wire logic [`SMCT_DATA_W-1:0]    wdata,
  // Read port
  input  wire logic                       re,
  input  wire logic [`SMCT_MEM_AW-1:0]    raddr,
  output logic      [`SMCT_DATA_W-1:0]    rdata_q
);

  logic [`SMCT_DATA_W-1:0] store_q [0:(1<<`SMCT_MEM_AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      for (int i = 0; i < `SMCT_LANES; i++) begin
        if (lane_we[i]) begin
          store_q[waddr][i*`SMCT_LANE_W +: `SMCT_LANE_W] <= wdata[i*`SMCT_LANE_W +: `SMCT_LANE_W];
        end
      end
    end
  end

  // Read data are frozen with the suspended clock so a paused burst resumes intact.
  always_ff @(posedge clk) begin
    if (re) begin
      rdata_q <= store_q[raddr];
    end
  end

endmodule

/* File: hw/smct_core.sv */
// Command-timing core of a 72-bit synchronous DRAM module with an Avalon-MM register slave.
`timescale 1ns/1ns
`include "smct_consts.svh"
module smct_core (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // Command pins
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire smct_pkg::smct_cmd_t        cmd,
  input  wire logic                       bank,
  input  wire logic [`SMCT_ROW_W-1:0]     addr,
  input  wire logic [`SMCT_LANES-1:0]     byte_lane_mask,
  // Data pins
  input  wire logic [`SMCT_DATA_W-1:0]    dq_in,
  output logic      [`SMCT_DATA_W-1:0]    dq_out,
  output logic      [`SMCT_LANES-1:0]     dq_oe_n,
  // Avalon-MM register slave
  input  wire logic [3:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest
);

  function automatic logic [`SMCT_MEM_AW-1:0] mem_index(input logic b, input logic [`SMCT_ROW_W-1:0] row,
                                                        input logic [`SMCT_COL_W-1:0] col);
    mem_index = {b, row[2:0], col[3:0]};
  endfunction

  function automatic logic [2:0] first_left(input logic [1:0] code);
    first_left = 3'((4'h1 << code) - 4'h1);
  endfunction

  function automatic logic [`SMCT_COL_W-1:0] next_col(input logic [`SMCT_COL_W-1:0] col, input logic [1:0] code);
    logic [`SMCT_COL_W-1:0] msk;
    msk = `SMCT_COL_W'((9'h1 << code) - 9'h1);
    next_col = (col & ~msk) | (`SMCT_COL_W'(col + 9'h1) & msk);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic                        cke_q, cke_qq, self_ref_q, ctrl_lat3_q, waitreq_q;
  logic [1:0]                  ctrl_bl_q, open_q;
  logic [`SMCT_ROW_W-1:0]      row_q [0:1];
  smct_pkg::smct_burst_t       burst_q;
  logic                        burst_bank_q, burst_close_q;
  logic [`SMCT_COL_W-1:0]      burst_col_q;
  logic [2:0]                  burst_left_q;
  logic                        rv1_q, rv2_q, dq_valid_q, rd_drive_q;
  logic [`SMCT_DATA_W-1:0]     stage_q, dq_out_q, mem_rdata;
  logic [`SMCT_LANES-1:0]      m1_q, m2_q, dq_oe_n_q;
  logic [31:0]                 readdata_q, reg_word;
  logic                        take, rd_take, wr_take, pre_hit, burst_end, close_now, close_bank;
  logic                        rv0, pcl_d, pcl_q, drive_d, mem_we, bus_wr;
  logic [`SMCT_LANES-1:0]      mem_lane_we;
  logic [`SMCT_MEM_AW-1:0]     mem_waddr, mem_raddr;

  assign dq_out          = dq_out_q;
  assign dq_oe_n         = dq_oe_n_q;
  assign avs_readdata    = readdata_q;
  assign avs_waitrequest = waitreq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock enable acts one edge late: every enabled register below looks at cke_q.
  always_ff @(posedge clk) begin
    if (srst) begin
      cke_q  <= 1'b0;
      cke_qq <= 1'b0;
    end else begin
      cke_q  <= cke;
      cke_qq <= cke_q;
    end
  end

  assign take    = cke_q && !cs_n;
  assign rd_take = take && (cmd == smct_pkg::read_cmd || cmd == smct_pkg::read_autoclose_cmd);
  assign wr_take = take && (cmd == smct_pkg::write_cmd || cmd == smct_pkg::write_autoclose_cmd);
  assign pre_hit = take && (cmd == smct_pkg::all_bank_precharge_cmd ||
                            (cmd == smct_pkg::bank_precharge_cmd && bank == burst_bank_q));
  assign burst_end = cke_q && burst_q != smct_pkg::burst_idle && burst_left_q == 3'h0 &&
                     !rd_take && !wr_take && !pre_hit;
  assign close_now  = (burst_end && burst_close_q) ||
                      (wr_take && cmd == smct_pkg::write_autoclose_cmd && ctrl_bl_q == 2'h0);
  assign close_bank = wr_take ? bank : burst_bank_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Burst sequencer; a new column command simply restarts it.
  always_ff @(posedge clk) begin
    if (srst) begin
      burst_q       <= smct_pkg::burst_idle;
      burst_bank_q  <= 1'b0;
      burst_close_q <= 1'b0;
      burst_col_q   <= '0;
      burst_left_q  <= 3'h0;
    end else if (cke_q) begin
      if (rd_take) begin
        burst_q       <= smct_pkg::burst_read;
        burst_bank_q  <= bank;
        burst_close_q <= (cmd == smct_pkg::read_autoclose_cmd);
        burst_col_q   <= addr[`SMCT_COL_W-1:0];
        burst_left_q  <= first_left(ctrl_bl_q);
      end else if (wr_take) begin
        burst_q       <= (ctrl_bl_q == 2'h0) ? smct_pkg::burst_idle : smct_pkg::burst_write;
        burst_bank_q  <= bank;
        burst_close_q <= (cmd == smct_pkg::write_autoclose_cmd);
        burst_col_q   <= next_col(addr[`SMCT_COL_W-1:0], ctrl_bl_q);
        burst_left_q  <= 3'(first_left(ctrl_bl_q) - 3'h1);
      end else if (pre_hit) begin
        burst_q <= smct_pkg::burst_idle;
      end else begin
        unique case (burst_q)
          smct_pkg::burst_idle: begin
            burst_q <= smct_pkg::burst_idle;
          end
          smct_pkg::burst_read, smct_pkg::burst_write: begin
            if (burst_left_q == 3'h0) begin
              burst_q <= smct_pkg::burst_idle;
            end else begin
              burst_left_q <= 3'(burst_left_q - 3'h1);
              burst_col_q  <= next_col(burst_col_q, ctrl_bl_q);
            end
          end
          default: begin
            burst_q <= smct_pkg::burst_idle;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Open rows per bank.
  always_ff @(posedge clk) begin
    if (srst) begin
      open_q   <= 2'h0;
      row_q[0] <= '0;
      row_q[1] <= '0;
    end else if (cke_q) begin
      if (close_now) begin
        open_q[close_bank] <= 1'b0;
      end
      if (take && cmd == smct_pkg::row_activate_cmd) begin
        row_q[bank]  <= addr;
        open_q[bank] <= 1'b1;
      end else if (take && cmd == smct_pkg::bank_precharge_cmd) begin
        open_q[bank] <= 1'b0;
      end else if (take && cmd == smct_pkg::all_bank_precharge_cmd) begin
        open_q <= 2'h0;
      end
    end
  end

  // Self refresh lasts until the clock is re-enabled after having been stopped.
  always_ff @(posedge clk) begin
    if (srst) begin
      self_ref_q <= 1'b0;
    end else if (take && cmd == smct_pkg::self_refresh_entry_cmd) begin
      self_ref_q <= 1'b1;
    end else if (cke_q && !cke_qq) begin
      self_ref_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage; write data and mask are taken on the very edge of the write command.
  assign mem_we      = cke_q && (wr_take || (burst_q == smct_pkg::burst_write && !rd_take && !pre_hit));
  assign mem_lane_we = ~byte_lane_mask;
  assign mem_waddr   = wr_take ? mem_index(bank, row_q[bank], addr[`SMCT_COL_W-1:0])
                               : mem_index(burst_bank_q, row_q[burst_bank_q], burst_col_q);
  assign mem_raddr   = mem_index(burst_bank_q, row_q[burst_bank_q], burst_col_q);

  smct_mem u_mem (
    .clk     (clk),
    .we      (mem_we),
    .lane_we (mem_lane_we),
    .waddr   (mem_waddr),
    .wdata   (dq_in),
    .re      (cke_q),
    .raddr   (mem_raddr),
    .rdata_q (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read pipeline; a write command cuts it short so the bus is free for write data.
  assign rv0     = (burst_q == smct_pkg::burst_read);
  assign pcl_d   = ctrl_lat3_q ? rv1_q : rv0;
  assign pcl_q   = ctrl_lat3_q ? rv2_q : rv1_q;
  assign drive_d = (pcl_d || pcl_q) && !wr_take;

  always_ff @(posedge clk) begin
    if (srst) begin
      rv1_q      <= 1'b0;
      rv2_q      <= 1'b0;
      dq_valid_q <= 1'b0;
      rd_drive_q <= 1'b0;
      stage_q    <= '0;
      dq_out_q   <= '0;
    end else if (cke_q) begin
      rv1_q      <= rv0 && !wr_take;
      rv2_q      <= rv1_q && !wr_take;
      stage_q    <= mem_rdata;
      dq_out_q   <= ctrl_lat3_q ? stage_q : mem_rdata;
      dq_valid_q <= pcl_q && !wr_take;
      rd_drive_q <= drive_d;
    end
  end

  // Mask pipeline is two stages deep so a masked lane floats on the second edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      m1_q      <= '0;
      m2_q      <= '0;
      dq_oe_n_q <= '1;
    end else if (cke_q) begin
      m1_q      <= byte_lane_mask;
      m2_q      <= m1_q;
      dq_oe_n_q <= drive_d ? m2_q : '1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode register: a mode-set command wins over a bus write in the same cycle.
  assign bus_wr = avs_write && !waitreq_q && avs_address[3:2] == 2'(`SMCT_CTRL_ADDR >> 2) &&
                  avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_bl_q   <= `SMCT_CTRL_BL_RST;
      ctrl_lat3_q <= `SMCT_CTRL_LAT3_RST;
    end else if (take && cmd == smct_pkg::mode_set_cmd) begin
      if (addr[`SMCT_MS_BL_LSB+2] == 1'b0) begin
        ctrl_bl_q <= addr[`SMCT_MS_BL_LSB +: 2];
      end
      if (addr[`SMCT_MS_CL_LSB +: 3] == `SMCT_MS_CL2 || addr[`SMCT_MS_CL_LSB +: 3] == `SMCT_MS_CL3) begin
        ctrl_lat3_q <= (addr[`SMCT_MS_CL_LSB +: 3] == `SMCT_MS_CL3);
      end
    end else if (bus_wr) begin
      ctrl_bl_q   <= avs_writedata[`SMCT_CTRL_BL_LSB +: 2];
      ctrl_lat3_q <= avs_writedata[`SMCT_CTRL_LAT3_BIT];
    end
  end

  always_comb begin
    reg_word = 32'h0;
    if (avs_address[3:2] == 2'(`SMCT_CTRL_ADDR >> 2)) begin
      reg_word[`SMCT_CTRL_BL_LSB +: 2] = ctrl_bl_q;
      reg_word[`SMCT_CTRL_LAT3_BIT]    = ctrl_lat3_q;
    end else if (avs_address[3:2] == 2'(`SMCT_STAT_ADDR >> 2)) begin
      reg_word[`SMCT_STAT_OPEN_LSB +: 2] = open_q;
      reg_word[`SMCT_STAT_SELF_BIT]      = self_ref_q;
      reg_word[`SMCT_STAT_SUSP_BIT]      = !cke_q;
      reg_word[`SMCT_STAT_RD_BIT]        = (burst_q == smct_pkg::burst_read);
      reg_word[`SMCT_STAT_WR_BIT]        = (burst_q == smct_pkg::burst_write);
      reg_word[`SMCT_STAT_LAT3_BIT]      = ctrl_lat3_q;
    end
  end

  // One wait state on every access keeps read data straight from a flip-flop.
  always_ff @(posedge clk) begin
    if (srst) begin
      waitreq_q  <= 1'b1;
      readdata_q <= 32'h0;
    end else begin
      waitreq_q <= !((avs_read || avs_write) && waitreq_q);
      if (avs_read && waitreq_q) begin
        readdata_q <= reg_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_quiet;
    cke_q && !wr_take;
  endsequence

  sequence s_pre_cl2;
    pre_hit && !ctrl_lat3_q ##1 (cke_q && !rd_take) [*2];
  endsequence

  sequence s_pre_cl3;
    pre_hit && ctrl_lat3_q ##1 (cke_q && !rd_take) [*3];
  endsequence

  chk_cmd_edge: assert property (@(posedge clk) disable iff (srst)
    $changed(dq_out_q) |-> $past(cke_q)) else $error("data output changed on a suspended edge");

  chk_select_gate: assert property (@(posedge clk) disable iff (srst)
    (cs_n && cke_q && cmd == smct_pkg::read_cmd && burst_q == smct_pkg::burst_idle) |=>
    burst_q == smct_pkg::burst_idle) else $error("deselected read command was taken");

  chk_suspend_hold: assert property (@(posedge clk) disable iff (srst)
    !cke |=> ##1 ($stable(dq_out_q) && $stable(burst_q))) else $error("state moved one cycle after clock enable fell");

  chk_burst_restart: assert property (@(posedge clk) disable iff (srst)
    (burst_q != smct_pkg::burst_idle && rd_take) |=>
    (burst_col_q == $past(addr[`SMCT_COL_W-1:0]) && burst_left_q == $past(first_left(ctrl_bl_q))))
    else $error("interrupting read did not restart the burst");

  chk_wmask_same: assert property (@(posedge clk) disable iff (srst)
    wr_take |-> (mem_we && mem_lane_we == ~byte_lane_mask &&
                 mem_waddr == mem_index(bank, row_q[bank], addr[`SMCT_COL_W-1:0])))
    else $error("write beat not stored with its own mask on the command edge");

  chk_rmask_two: assert property (@(posedge clk) disable iff (srst)
    ($past(cke_q) && $past(cke_q, 2) && $past(cke_q, 3) && rd_drive_q) |->
    dq_oe_n_q == $past(byte_lane_mask, `SMCT_READ_MASK_LAT + 1)) else $error("read mask not applied two cycles later");

  chk_float_cl2: assert property (@(posedge clk) disable iff (srst)
    s_pre_cl2 |=> &dq_oe_n_q) else $error("outputs still driven two cycles after precharge");

  chk_float_cl3: assert property (@(posedge clk) disable iff (srst)
    s_pre_cl3 |=> &dq_oe_n_q) else $error("outputs still driven three cycles after precharge");

  chk_first_beat: assert property (@(posedge clk) disable iff (srst)
    (rd_take && !ctrl_lat3_q ##1 s_quiet [*2]) |-> rd_drive_q ##1 dq_valid_q)
    else $error("first read beat not on the latency edge");

endmodule

/* File: tb/smct_ctrl_model.sv */
// Behavioural memory controller that drives the command and write-data pins of the module.
`timescale 1ns/1ns
`include "smct_consts.svh"
module smct_ctrl_model #(
  parameter int PERIOD_NS = 20
) (
  // Clock
  input  wire logic                      clk,
  // Command pins
  output logic                           cke,
  output logic                           cs_n,
  output smct_pkg::smct_cmd_t            cmd,
  output logic                           bank,
  output logic [`SMCT_ROW_W-1:0]         addr,
  output logic [`SMCT_LANES-1:0]         byte_lane_mask,
  // Write data
  output logic [`SMCT_DATA_W-1:0]        dq_in
);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cke = 1'b1;
    cs_n = 1'b0;
    cmd = smct_pkg::cmd_nop;
    bank = 1'b0;
    addr = '0;
    byte_lane_mask = '0;
    dq_in = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every task starts just after a rising edge; issue returns just after the edge that took its command, write_burst after the edge of its last beat.
  task automatic issue(input smct_pkg::smct_cmd_t c, input logic b, input logic [10:0] a, input logic desel);
    cs_n <= desel;
    cmd <= c;
    bank <= b;
    addr <= a;
    @(posedge clk);
    cs_n <= 1'b0;
    cmd <= smct_pkg::cmd_nop;
    addr <= ~a;
  endtask

  // Spacing is rounded up to whole cycles, with no-operations meanwhile.
  task automatic wait_ns(input int ns);
    repeat ((ns + PERIOD_NS - 1) / PERIOD_NS - 1) @(posedge clk);
  endtask

  task automatic write_burst(input logic [10:0] a, input logic [71:0] d[4], input logic [7:0] m1);
    cmd <= smct_pkg::write_cmd;
    bank <= 1'b0;
    addr <= a;
    dq_in <= d[0];
    @(posedge clk);
    cmd <= smct_pkg::cmd_nop;
    addr <= ~a;
    for (int i = 1; i < 4; i++) begin
      dq_in <= d[i];
      byte_lane_mask <= (i == 1) ? m1 : 8'h00;
      @(posedge clk);
    end
    // Released data shows the inverse, so a stale beat can never look correct.
    dq_in <= ~d[3];
    byte_lane_mask <= 8'h00;
  endtask

  task automatic mask_pulse(input logic [7:0] m);
    byte_lane_mask <= m;
    @(posedge clk);
    byte_lane_mask <= 8'h00;
  endtask

  task automatic set_cke(input logic v);
    cke <= v;
    @(posedge clk);
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench: register access over Avalon-MM and command timing through the controller model.
`timescale 1ns/1ns
`include "smct_consts.svh"
module testbench;
  logic                        clk;
  logic                        srst;
  logic                        cke, cs_n, bank;
  smct_pkg::smct_cmd_t         cmd;
  logic [`SMCT_ROW_W-1:0]      addr;
  logic [`SMCT_LANES-1:0]      byte_lane_mask, dq_oe_n;
  logic [`SMCT_DATA_W-1:0]     dq_in, dq_out;
  logic [3:0]                  avs_address, avs_byteenable;
  logic                        avs_read, avs_write, avs_waitrequest;
  logic [31:0]                 avs_writedata, avs_readdata, rd;
  logic [71:0]                 wa[4], wb[4], exp_d[4];
  int                          n_errors, checks, cycles, cl;

  ////////////////////////////////////////////////////////////////////////////
  smct_ctrl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .bank(bank), .addr(addr),
    .byte_lane_mask(byte_lane_mask), .dq_in(dq_in));
  smct_core dut (.clk(clk), .srst(srst), .cke(cke), .cs_n(cs_n), .cmd(cmd), .bank(bank), .addr(addr),
    .byte_lane_mask(byte_lane_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The request stays put until waitrequest is seen low at an edge; only the timeout ends the wait.
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  // Lane 2 is masked on the edge after the read, so exactly one beat must come out undriven there.
  task automatic read_check(input int lat);
    ctl.issue(smct_pkg::read_cmd, 1'b0, 11'h000, 1'b0);
    ctl.mask_pulse(8'h04);
    repeat (lat - 2) @(posedge clk);
    #1;
    chk("drive_start", dq_oe_n, 8'h00);
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      #1;
      chk("read_lanes", dq_oe_n, (j == 3 - lat) ? 8'h04 : 8'h00);
      if (j != 3 - lat) chk("read_data", dq_out, exp_d[j]);
    end
    @(posedge clk);
    #1;
    chk("read_end", dq_oe_n, 8'hff);
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    for (int i = 0; i < 4; i++) begin
      wa[i] = {8{9'h010 + 9'(i)}};
      wb[i] = {8{9'h120 + 9'(i)}};
      exp_d[i] = wb[i];
    end
    exp_d[1][8:0] = wa[1][8:0];
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    av(1'b0, 4'h0, 32'h0, rd);
    chk("ctrl_reset", rd, 32'h12);
    av(1'b1, 4'h4, 32'hff, rd);
    av(1'b0, 4'h4, 32'h0, rd);
    chk("status_reset", rd, 32'h40);
    av(1'b0, 4'h8, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    for (int l = 0; l < 2; l++) begin
      cl = (l == 0) ? 3 : 2;
      av(1'b1, 4'h0, (l == 0) ? 32'h12 : 32'h02, rd);
      av(1'b0, 4'h4, 32'h0, rd);
      chk("status_latency", rd, (l == 0) ? 32'h40 : 32'h00);
      ctl.issue(smct_pkg::row_activate_cmd, 1'b0, 11'h000, 1'b0);
      ctl.wait_ns(72);
      if (l == 0) begin
        ctl.write_burst(11'h000, wa, 8'h00);
        ctl.wait_ns(40);
        ctl.write_burst(11'h000, wb, 8'h01);
        ctl.wait_ns(40);
      end
      read_check(cl);
      ctl.issue(smct_pkg::read_cmd, 1'b0, 11'h000, 1'b1);
      repeat (cl + 3) begin
        @(posedge clk);
        #1;
        chk("deselected", dq_oe_n, 8'hff);
      end
      @(posedge clk);
      ctl.issue(smct_pkg::read_cmd, 1'b0, 11'h000, 1'b0);
      ctl.issue(smct_pkg::bank_precharge_cmd, 1'b0, 11'h000, 1'b0);
      repeat (cl - 1) @(posedge clk);
      #1;
      chk("still_driving", dq_oe_n, 8'h00);
      @(posedge clk);
      #1;
      chk("floated", dq_oe_n, 8'hff);
      @(posedge clk);
      ctl.wait_ns(36);
    end
    ctl.set_cke(1'b0);
    av(1'b0, 4'h4, 32'h0, rd);
    chk("suspended", rd, 32'h08);
    ctl.set_cke(1'b1);
    av(1'b0, 4'h4, 32'h0, rd);
    chk("resumed", rd, 32'h00);
    // A second reset in mid-run must bring the control register back to its defaults.
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    av(1'b0, 4'h0, 32'h0, rd);
    chk("ctrl_rereset", rd, 32'h12);
    avs_byteenable <= 4'he;
    av(1'b1, 4'h0, 32'h0, rd);
    avs_byteenable <= 4'hf;
    av(1'b0, 4'h0, 32'h0, rd);
    chk("ctrl_no_lane0", rd, 32'h12);
    ctl.issue(smct_pkg::row_activate_cmd, 1'b1, 11'h005, 1'b0);
    ctl.wait_ns(72);
    av(1'b0, 4'h4, 32'h0, rd);
    chk("bank1_open", rd, 32'h42);
    ctl.issue(smct_pkg::read_autoclose_cmd, 1'b1, 11'h000, 1'b0);
    ctl.wait_ns(100);
    av(1'b0, 4'h4, 32'h0, rd);
    chk("read_autoclosed", rd, 32'h40);
    ctl.issue(smct_pkg::row_activate_cmd, 1'b1, 11'h005, 1'b0);
    ctl.wait_ns(72);
    ctl.issue(smct_pkg::write_autoclose_cmd, 1'b1, 11'h000, 1'b0);
    ctl.wait_ns(100);
    av(1'b0, 4'h4, 32'h0, rd);
    chk("write_autoclosed", rd, 32'h40);
    ctl.issue(smct_pkg::auto_refresh_cmd, 1'b0, 11'h000, 1'b0);
    ctl.wait_ns(108);
    ctl.issue(smct_pkg::mode_set_cmd, 1'b0, 11'h023, 1'b0);
    ctl.wait_ns(24);
    av(1'b0, 4'h0, 32'h0, rd);
    chk("mode_set", rd, 32'h03);
    wrap_up();
  end
endmodule
